// >>> core/byte_port_if.sv
`timescale 1ns/10ps
`default_nettype none
interface byte_port_if #(parameter int AW = 6);
   logic [AW-1:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic we;
   logic clear;
   modport ctrl (output addr, wdata, we, clear, input rdata);
   modport mem (input addr, wdata, we, clear, output rdata);
endinterface
`default_nettype wire

// >>> core/flash_block_program_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module flash_block_program_sequencer #(
   parameter int PROG_US = flash_seq_pkg::PROG_TIME_US,
   parameter int EE_US = flash_seq_pkg::EE_TIME_US
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic external_master_reset,
   input wire logic watchdog_reset,
   output logic cpu_stall,
   output logic write_complete_irq_flag,
   output logic [flash_seq_pkg::PTR_W-1:0] pf_addr,
   output logic [7:0] pf_wdata,
   output logic pf_write,
   output logic pf_erase,
   input wire logic [7:0] pf_rdata
);
   import flash_seq_pkg::*;

   byte_port_if #(.AW(HOLD_AW)) hold ();
   byte_port_if #(.AW(EE_AW)) ee ();

   holding_buffer u_hold (
      .pclk(pclk),
      .presetn(presetn),
      .port(hold.mem)
   );

   nv_data_array u_ee (
      .pclk(pclk),
      .port(ee.mem)
   );

   // -----------------------------------------------------------------
   // State.
   // -----------------------------------------------------------------
   seq_state_t state_reg, state_next;
   logic [PTR_W-1:0] ptr_reg, ptr_next;
   logic [7:0] latch_reg, latch_next;
   logic pgm_reg, pgm_next;
   logic cfg_reg, cfg_next;
   logic erase_reg, erase_next;
   logic abort_reg, abort_next;
   logic write_enable_bit_reg, write_enable_bit_next;
   logic wr_reg, wr_next;
   logic op_pgm_reg, op_pgm_next;
   logic [7:0] nv_data_reg, nv_data_next;
   logic [7:0] nv_addr_reg, nv_addr_next;
   logic irq_reg, irq_next;
   logic [1:0] arm_reg, arm_next;
   logic [HOLD_AW-1:0] idx_reg, idx_next;
   logic [6:0] tick_reg, tick_next;
   logic [19:0] time_reg, time_next;
   logic rd_pend_reg, rd_pend_next;
   logic [31:0] prdata_reg, prdata_next;
   logic [PTR_W-1:0] pf_addr_reg, pf_addr_next;
   logic [7:0] pf_wdata_reg, pf_wdata_next;
   logic pf_write_reg, pf_write_next;
   logic pf_erase_reg, pf_erase_next;

   logic busy, acc, wr_acc, setup, tbl_rd_req, tick, soft_rst;
   logic mapped;
   logic [PTR_W-1:0] eff_ptr, ptr_after;
   logic [20:0] p_inc, p_dec;
   logic [7:0] ctl_view;

   // -----------------------------------------------------------------
   // Bus decode.
   // -----------------------------------------------------------------
   assign busy = state_reg != S_IDLE;
   assign setup = psel && !penable;
   assign tbl_rd_req = psel && penable && pwrite && !busy &&
                       paddr == OFF_TABLE_OP && !pwdata[OP_DIR];
   assign pready = !tbl_rd_req || rd_pend_reg;
   assign acc = psel && penable && pready;
   assign wr_acc = acc && pwrite;
   assign soft_rst = external_master_reset || watchdog_reset;
   assign tick = tick_reg == 7'(TICK_CYCLES - 1);

   always_comb begin
      unique case (paddr)
         OFF_PTR_LOW, OFF_PTR_HIGH, OFF_PTR_UPPER, OFF_LATCH,
         OFF_TABLE_OP, OFF_UNLOCK, OFF_CONTROL, OFF_NV_DATA,
         OFF_NV_ADDR, OFF_STATUS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !mapped;

   // Pointer arithmetic touches only the low 21 bits.
   assign p_inc = ptr_reg[20:0] + 21'h1;
   assign p_dec = ptr_reg[20:0] - 21'h1;
   assign eff_ptr = (pwdata[1:0] == MODE_PRE_INC) ?
                    {ptr_reg[21], p_inc} : ptr_reg;
   always_comb begin
      unique case (pwdata[1:0])
         MODE_KEEP: ptr_after = ptr_reg;
         MODE_POST_DEC: ptr_after = {ptr_reg[21], p_dec};
         MODE_POST_INC, MODE_PRE_INC: ptr_after = {ptr_reg[21], p_inc};
      endcase
   end

   assign ctl_view = {pgm_reg, cfg_reg, 1'b0, erase_reg, abort_reg,
                      write_enable_bit_reg, wr_reg, 1'b0};

   // -----------------------------------------------------------------
   // Next-state logic.
   // -----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      ptr_next = ptr_reg;
      latch_next = latch_reg;
      pgm_next = pgm_reg;
      cfg_next = cfg_reg;
      erase_next = erase_reg;
      abort_next = abort_reg;
      write_enable_bit_next = write_enable_bit_reg;
      wr_next = wr_reg;
      op_pgm_next = op_pgm_reg;
      nv_data_next = nv_data_reg;
      nv_addr_next = nv_addr_reg;
      irq_next = irq_reg;
      arm_next = arm_reg;
      idx_next = idx_reg;
      tick_next = tick_reg;
      time_next = time_reg;
      rd_pend_next = 1'b0;
      prdata_next = prdata_reg;
      pf_addr_next = pf_addr_reg;
      pf_wdata_next = pf_wdata_reg;
      pf_write_next = 1'b0;
      pf_erase_next = 1'b0;
      hold.we = 1'b0;
      hold.clear = 1'b0;
      hold.wdata = latch_reg;
      hold.addr = eff_ptr[HOLD_AW-1:0];
      ee.we = 1'b0;
      ee.clear = 1'b0;
      ee.wdata = nv_data_reg;
      ee.addr = nv_addr_reg;

      if (setup) begin
         unique case (paddr)
            OFF_PTR_LOW: prdata_next = {24'h0, ptr_reg[7:0]};
            OFF_PTR_HIGH: prdata_next = {24'h0, ptr_reg[15:8]};
            OFF_PTR_UPPER: prdata_next = {26'h0, ptr_reg[21:16]};
            OFF_LATCH: prdata_next = {24'h0, latch_reg};
            OFF_CONTROL: prdata_next = {24'h0, ctl_view};
            OFF_NV_DATA: prdata_next = {24'h0, nv_data_reg};
            OFF_NV_ADDR: prdata_next = {24'h0, nv_addr_reg};
            OFF_STATUS: prdata_next = {30'h0, cpu_stall, irq_reg};
            default: prdata_next = 32'h0;
         endcase
      end

      // A table read fetches the byte one cycle after the address.
      if (tbl_rd_req && !rd_pend_reg) begin
         rd_pend_next = 1'b1;
         pf_addr_next = eff_ptr;
      end
      if (tbl_rd_req && rd_pend_reg) begin
         latch_next = pf_rdata;
         ptr_next = ptr_after;
      end

      if (acc) begin
         arm_next = ARM_NONE;
      end
      if (wr_acc && paddr == OFF_UNLOCK) begin
         if (pwdata[7:0] == UNLOCK_FIRST) begin
            arm_next = ARM_FIRST;
         end else if (pwdata[7:0] == UNLOCK_SECOND &&
                      arm_reg == ARM_FIRST) begin
            arm_next = ARM_READY;
         end
      end

      if (wr_acc && !busy) begin
         unique case (paddr)
            OFF_PTR_LOW: ptr_next[7:0] = pwdata[7:0];
            OFF_PTR_HIGH: ptr_next[15:8] = pwdata[7:0];
            OFF_PTR_UPPER: ptr_next[21:16] = pwdata[5:0];
            OFF_LATCH: latch_next = pwdata[7:0];
            OFF_NV_DATA: nv_data_next = pwdata[7:0];
            OFF_NV_ADDR: nv_addr_next = pwdata[7:0];
            OFF_TABLE_OP: begin
               if (pwdata[OP_DIR]) begin
                  hold.we = 1'b1;
                  ptr_next = ptr_after;
               end
            end
            OFF_CONTROL: begin
               pgm_next = pwdata[CTL_PGM];
               cfg_next = pwdata[CTL_CFG];
               erase_next = pwdata[CTL_ERASE];
               abort_next = pwdata[CTL_ABORT];
               write_enable_bit_next = pwdata[CTL_WRITE_ENABLE_BIT];
               if (pwdata[CTL_RD] && !pwdata[CTL_PGM] &&
                   !pwdata[CTL_CFG]) begin
                  nv_data_next = ee.rdata;
               end
               if (pwdata[CTL_WR] && write_enable_bit_reg &&
                   arm_reg == ARM_READY) begin
                  if (pwdata[CTL_CFG]) begin
                     abort_next = 1'b1;
                  end else begin
                     wr_next = 1'b1;
                     abort_next = 1'b1;
                     op_pgm_next = pwdata[CTL_PGM];
                     tick_next = 7'h0;
                     time_next = pwdata[CTL_PGM] ? 20'(PROG_US) :
                                 20'(EE_US);
                     if (!pwdata[CTL_PGM]) begin
                        ee.we = 1'b1;
                        state_next = S_TIME;
                     end else if (pwdata[CTL_ERASE]) begin
                        pf_erase_next = 1'b1;
                        pf_addr_next = {ptr_reg[21:6], 6'h0};
                        state_next = S_TIME;
                     end else begin
                        idx_next = '0;
                        state_next = S_LOAD;
                     end
                  end
               end
            end
            default: ;
         endcase
      end

      if (wr_acc && paddr == OFF_STATUS && pwdata[0]) begin
         irq_next = 1'b0;
      end

      if (busy) begin
         tick_next = tick ? 7'h0 : tick_reg + 7'h1;
         if (tick && time_reg != 20'h0) begin
            time_next = time_reg - 20'h1;
         end
      end

      unique case (state_reg)
         S_IDLE: ;
         S_LOAD: begin
            hold.addr = idx_reg;
            pf_addr_next = {ptr_reg[21:6], idx_reg};
            pf_wdata_next = hold.rdata;
            pf_write_next = hold.rdata != HOLD_RESET;
            idx_next = idx_reg + 6'h1;
            if (idx_reg == 6'(BLOCK_BYTES - 1)) begin
               state_next = S_TIME;
            end
         end
         S_TIME: begin
            if (time_reg == 20'h0) begin
               state_next = S_IDLE;
               wr_next = 1'b0;
               abort_next = 1'b0;
               erase_next = 1'b0;
               irq_next = 1'b1;
               hold.clear = 1'b1;
            end
         end
      endcase

      if (soft_rst) begin
         state_next = S_IDLE;
         abort_next = abort_reg || busy;
         wr_next = 1'b0;
         write_enable_bit_next = 1'b0;
         erase_next = 1'b0;
         arm_next = ARM_NONE;
         pf_write_next = 1'b0;
         pf_erase_next = 1'b0;
         hold.clear = 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // Registers.
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= S_IDLE;
         ptr_reg <= '0;
         latch_reg <= 8'h00;
         pgm_reg <= 1'b0;
         cfg_reg <= 1'b0;
         erase_reg <= 1'b0;
         abort_reg <= 1'b0;
         write_enable_bit_reg <= 1'b0;
         wr_reg <= 1'b0;
         op_pgm_reg <= 1'b0;
         nv_data_reg <= 8'h00;
         nv_addr_reg <= 8'h00;
         irq_reg <= 1'b0;
         arm_reg <= ARM_NONE;
         idx_reg <= '0;
         tick_reg <= 7'h0;
         time_reg <= 20'h0;
         rd_pend_reg <= 1'b0;
         prdata_reg <= 32'h0;
         pf_addr_reg <= '0;
         pf_wdata_reg <= 8'hff;
         pf_write_reg <= 1'b0;
         pf_erase_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         ptr_reg <= ptr_next;
         latch_reg <= latch_next;
         pgm_reg <= pgm_next;
         cfg_reg <= cfg_next;
         erase_reg <= erase_next;
         abort_reg <= abort_next;
         write_enable_bit_reg <= write_enable_bit_next;
         wr_reg <= wr_next;
         op_pgm_reg <= op_pgm_next;
         nv_data_reg <= nv_data_next;
         nv_addr_reg <= nv_addr_next;
         irq_reg <= irq_next;
         arm_reg <= arm_next;
         idx_reg <= idx_next;
         tick_reg <= tick_next;
         time_reg <= time_next;
         rd_pend_reg <= rd_pend_next;
         prdata_reg <= prdata_next;
         pf_addr_reg <= pf_addr_next;
         pf_wdata_reg <= pf_wdata_next;
         pf_write_reg <= pf_write_next;
         pf_erase_reg <= pf_erase_next;
      end
   end

   // -----------------------------------------------------------------
   // Outputs.
   // -----------------------------------------------------------------
   // halt during long write.
   assign cpu_stall = wr_reg && op_pgm_reg;
   assign write_complete_irq_flag = irq_reg;
   assign prdata = prdata_reg;
   assign pf_addr = pf_addr_reg;
   assign pf_wdata = pf_wdata_reg;
   assign pf_write = pf_write_reg;
   assign pf_erase = pf_erase_reg;
endmodule // flash_block_program_sequencer
`default_nettype wire

// >>> core/flash_seq_pkg.sv
// Contract
// - Program flash only in 64-byte blocks.
// - Exactly 64 holding registers, one per byte.
// - Table write updates one holding register.
// - Long write halts CPU until timer ends.
// - On-chip timer sets write duration.
// - Holding registers FFh after reset, write.
// - FFh holding byte leaves flash byte unchanged.
// - Unlock 55h then 0AAh before write bit.
// - Program stall lasts about 2 ms.
// - Reset during write sets abort flag.
// - Data array byte reads and writes.
// - Data byte write erases then writes, timed.
// - Data address 8 bits, 256 locations.
// - Low six pointer bits select holding byte.
// - Completion flag set, held until cleared.
// - Write bit set by software, hardware clears.
// - Write bit blocked unless enable set.
package flash_seq_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int NS_PER_US = 1000;
   localparam int TICK_CYCLES = NS_PER_US / CLK_PERIOD_NS;
   localparam int PROG_TIME_MS = 2;
   localparam int EE_TIME_MS = 4;
   localparam int PROG_TIME_US = PROG_TIME_MS * 1000;
   localparam int EE_TIME_US = EE_TIME_MS * 1000;
   localparam int BLOCK_BYTES = 64;
   localparam int HOLD_AW = 6;
   localparam int EE_AW = 8;
   localparam int PTR_W = 22;
   localparam logic [7:0] HOLD_RESET = 8'hff;
   localparam logic [7:0] UNLOCK_FIRST = 8'h55;
   localparam logic [7:0] UNLOCK_SECOND = 8'haa;
   localparam logic [7:0] OFF_PTR_LOW = 8'h00;
   localparam logic [7:0] OFF_PTR_HIGH = 8'h04;
   localparam logic [7:0] OFF_PTR_UPPER = 8'h08;
   localparam logic [7:0] OFF_LATCH = 8'h0c;
   localparam logic [7:0] OFF_TABLE_OP = 8'h10;
   localparam logic [7:0] OFF_UNLOCK = 8'h14;
   localparam logic [7:0] OFF_CONTROL = 8'h18;
   localparam logic [7:0] OFF_NV_DATA = 8'h1c;
   localparam logic [7:0] OFF_NV_ADDR = 8'h20;
   localparam logic [7:0] OFF_STATUS = 8'h24;
   localparam int CTL_PGM = 7;
   localparam int CTL_CFG = 6;
   localparam int CTL_ERASE = 4;
   localparam int CTL_ABORT = 3;
   localparam int CTL_WRITE_ENABLE_BIT = 2;
   localparam int CTL_WR = 1;
   localparam int CTL_RD = 0;
   localparam int OP_DIR = 2;
   localparam logic [1:0] MODE_KEEP = 2'h0;
   localparam logic [1:0] MODE_POST_INC = 2'h1;
   localparam logic [1:0] MODE_POST_DEC = 2'h2;
   localparam logic [1:0] MODE_PRE_INC = 2'h3;
   localparam logic [1:0] ARM_NONE = 2'h0;
   localparam logic [1:0] ARM_FIRST = 2'h1;
   localparam logic [1:0] ARM_READY = 2'h2;
   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_LOAD = 3'b010,
      S_TIME = 3'b100
   } seq_state_t;
endpackage

// >>> core/holding_buffer.sv
`timescale 1ns/10ps
`default_nettype none
module holding_buffer
   import flash_seq_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   byte_port_if.mem port
);
   logic [7:0] hold_reg [BLOCK_BYTES];
   // -----------------------------------------------------------------
   // One register per block byte.
   // -----------------------------------------------------------------
   // one per byte.
   genvar i;
   for (i = 0; i < BLOCK_BYTES; i++) begin : g_hold
      logic [7:0] hold_next;
      always_comb begin
         hold_next = hold_reg[i];
         if (port.we && port.addr == HOLD_AW'(i)) begin
            hold_next = port.wdata;
         end
         if (port.clear) begin
            hold_next = HOLD_RESET;
         end
      end
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            hold_reg[i] <= 8'hff;
         end else begin
            hold_reg[i] <= hold_next;
         end
      end
   end
   assign port.rdata = hold_reg[port.addr];
endmodule // holding_buffer
`default_nettype wire

// >>> core/nv_data_array.sv
`timescale 1ns/10ps
`default_nettype none
module nv_data_array
   import flash_seq_pkg::*;
(
   input wire logic pclk,
   byte_port_if.mem port
);
   // -----------------------------------------------------------------
   // Nonvolatile bytes, kept across reset.
   // -----------------------------------------------------------------
   // 256 locations.
   logic [7:0] mem_reg [2**EE_AW];
   always_ff @(posedge pclk) begin
      if (port.we) begin
         mem_reg[port.addr] <= port.wdata;
      end
   end
   assign port.rdata = mem_reg[port.addr];
endmodule // nv_data_array
`default_nettype wire

// >>> tb/flash_array_model.sv
`timescale 1ns/10ps
`default_nettype none
module flash_array_model (
   input wire logic pclk,
   input wire logic [flash_seq_pkg::PTR_W-1:0] pf_addr,
   input wire logic [7:0] pf_wdata,
   input wire logic pf_write,
   input wire logic pf_erase,
   output logic [7:0] pf_rdata
);
   import flash_seq_pkg::*;
   logic [7:0] mem [0:4095];
   initial begin
      for (int i = 0; i < 4096; i++) mem[i] = 8'hff;
   end
   always @(posedge pclk) begin
      if (pf_erase) begin
         for (int i = 0; i < 64; i++) mem[{pf_addr[11:6], i[5:0]}] <= 8'hff;
      end else if (pf_write) begin
         mem[pf_addr[11:0]] <= mem[pf_addr[11:0]] & pf_wdata;
      end
   end
   assign pf_rdata = mem[pf_addr[11:0]];
endmodule // flash_array_model
`default_nettype wire

// >>> tb/flash_seq_checker.sv
`timescale 1ns/10ps
`default_nettype none
module flash_seq_checker #(
   parameter int PROG_US = 2,
   parameter int EE_US = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic external_master_reset,
   input wire logic watchdog_reset,
   input wire logic cpu_stall,
   input wire logic write_complete_irq_flag,
   input wire logic [flash_seq_pkg::PTR_W-1:0] pf_addr,
   input wire logic [7:0] pf_wdata,
   input wire logic pf_write,
   input wire logic pf_erase
);
   import flash_seq_pkg::*;
   // ----------------------------------------
   // Stall length counter
   // ----------------------------------------
   int stall_reg;
   int stall_next;
   logic soft_rst;
   logic clr_req;
   assign soft_rst = external_master_reset | watchdog_reset;
   assign clr_req = psel & penable & pwrite & (paddr == OFF_STATUS) &
                    pwdata[0];
   always_comb begin
      stall_next = cpu_stall ? stall_reg + 1 : 0;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stall_reg <= 0;
      end else begin
         stall_reg <= stall_next;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_stall_length: assert property ($fell(cpu_stall) && !$past(soft_rst)
      |-> stall_reg >= PROG_US * 100 && stall_reg <= PROG_US * 100 + 3)
      else $error("stall length out of range");
   a_stall_sets_flag: assert property (
      $fell(cpu_stall) && !$past(soft_rst) |-> write_complete_irq_flag)
      else $error("stall ended without flag");
   a_stall_holds: assert property ($rose(cpu_stall) |-> cpu_stall [*8])
      else $error("stall dropped early");
   a_pulse_in_stall: assert property (pf_write || pf_erase |-> cpu_stall)
      else $error("flash pulse outside timed write");
   a_skip_blank: assert property (pf_write |-> pf_wdata != HOLD_RESET)
      else $error("blank holding byte programmed");
   a_block_order: assert property (pf_write && $past(pf_write)
      |-> pf_addr[21:6] == $past(pf_addr[21:6])
      && pf_addr[5:0] > $past(pf_addr[5:0])) else $error("block address bad");
   a_erase_quiet: assert property (pf_erase
      |=> (!pf_erase && !pf_write) [*8]) else $error("erase not single");
   a_flag_sticky: assert property (write_complete_irq_flag && !clr_req
      |=> write_complete_irq_flag) else $error("flag lost");
   a_write_ready: assert property (psel && penable && pwrite
      && !(paddr == OFF_TABLE_OP && !pwdata[OP_DIR]) |-> pready)
      else $error("write waited");
   c_stall_start: cover property ($rose(cpu_stall));
   c_stall_end: cover property ($fell(cpu_stall));
   c_erase: cover property (pf_erase);
   c_program: cover property (pf_write);
endmodule // flash_seq_checker
bind flash_block_program_sequencer flash_seq_checker #(.PROG_US(PROG_US),
   .EE_US(EE_US)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .external_master_reset(external_master_reset),
   .watchdog_reset(watchdog_reset), .cpu_stall(cpu_stall),
   .write_complete_irq_flag(write_complete_irq_flag), .pf_addr(pf_addr),
   .pf_wdata(pf_wdata), .pf_write(pf_write), .pf_erase(pf_erase));
`default_nettype wire

// >>> tb/tb_flash_block_program_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module tb_flash_block_program_sequencer;
   import flash_seq_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic external_master_reset = 0, watchdog_reset = 0, err;
   logic [7:0] paddr = 0, pf_wdata, pf_rdata;
   logic [31:0] pwdata = 0, prdata, q;
   logic pready, pslverr, cpu_stall, write_complete_irq_flag, pf_write;
   logic pf_erase;
   logic [PTR_W-1:0] pf_addr;
   int failures = 0, checks = 0, cycles = 0, seed = 59208, blk, d;
   int exp_flash [4096];
   int hold [64];
   flash_block_program_sequencer #(.PROG_US(2), .EE_US(3)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .external_master_reset(external_master_reset),
      .watchdog_reset(watchdog_reset), .cpu_stall(cpu_stall),
      .write_complete_irq_flag(write_complete_irq_flag),
      .pf_addr(pf_addr), .pf_wdata(pf_wdata), .pf_write(pf_write),
      .pf_erase(pf_erase), .pf_rdata(pf_rdata));
   flash_array_model flash (.pclk(pclk), .pf_addr(pf_addr),
      .pf_wdata(pf_wdata), .pf_write(pf_write), .pf_erase(pf_erase),
      .pf_rdata(pf_rdata));
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles++;
      if (cycles > 40000) begin
         failures++;
         complete_run();
      end
   end
   task complete_run;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // ----------------------------------------
   // Bus cycles and sequences
   // ----------------------------------------
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      apb(1, a, v);
   endtask
   task rd(input logic [7:0] a);
      apb(0, a, 0);
   endtask
   task set_ptr;
      wr(OFF_PTR_UPPER, 0);
      wr(OFF_PTR_HIGH, blk >> 2);
      wr(OFF_PTR_LOW, (blk & 3) << 6);
   endtask
   task start(input logic [7:0] c);
      wr(OFF_CONTROL, c);
      wr(OFF_UNLOCK, UNLOCK_FIRST);
      wr(OFF_UNLOCK, UNLOCK_SECOND);
      wr(OFF_CONTROL, c | 8'h02);
   endtask
   task wait_done;
      int n;
      n = 0;
      do begin
         rd(OFF_STATUS);
         n++;
      end while (q[0] !== 1'b1 && n < 1000);
      check(q[0], 1);
      wr(OFF_STATUS, 1);
      rd(OFF_STATUS);
      check(q[0], 0);
      rd(OFF_CONTROL);
      check(q[1], 0);
   endtask
   task verify;
      set_ptr();
      for (int i = 0; i < 64; i++) begin
         wr(OFF_TABLE_OP, MODE_POST_INC);
         rd(OFF_LATCH);
         check(q, exp_flash[blk * 64 + i]);
      end
   endtask
   task program_block(input int pass);
      set_ptr();
      for (int i = 0; i < 64 && pass < 2; i++) begin
         d = $random(seed) & 8'hff;
         if (pass == 1 && i % 4 == 0) d = 8'hff;
         hold[i] = d;
         wr(OFF_LATCH, d);
         wr(OFF_TABLE_OP, 4 | MODE_POST_INC);
      end
      set_ptr();
      start(8'h84);
      rd(OFF_STATUS);
      check(q[1], 1);
      wait_done();
      for (int i = 0; i < 64; i++) begin
         exp_flash[blk * 64 + i] &= hold[i];
         hold[i] = 8'hff;
      end
      verify();
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      for (int i = 0; i < 4096; i++) exp_flash[i] = 8'hff;
      for (int i = 0; i < 64; i++) hold[i] = 8'hff;
      blk = $random(seed) & 63;
      repeat (8) @(posedge pclk);
      presetn <= 1;
      rd(OFF_STATUS);
      check(q, 0);
      rd(OFF_UNLOCK);
      check(q, 0);
      rd(8'h40);
      check({q[30:0], err}, 1);
      for (int k = 0; k < 3; k++) begin
         wr(OFF_CONTROL, k == 0 ? 8'h80 : 8'h84);
         wr(OFF_UNLOCK, k == 1 ? UNLOCK_SECOND : UNLOCK_FIRST);
         if (k == 2) rd(OFF_STATUS);
         wr(OFF_UNLOCK, k == 1 ? UNLOCK_FIRST : UNLOCK_SECOND);
         wr(OFF_CONTROL, k == 0 ? 8'h82 : 8'h86);
         rd(OFF_STATUS);
         check(q[1], 0);
      end
      for (int p = 0; p < 3; p++) program_block(p);
      set_ptr();
      wr(OFF_TABLE_OP, MODE_PRE_INC);
      rd(OFF_LATCH);
      check(q, exp_flash[blk * 64 + 1]);
      wr(OFF_TABLE_OP, MODE_POST_DEC);
      rd(OFF_LATCH);
      check(q, exp_flash[blk * 64 + 1]);
      wr(OFF_TABLE_OP, MODE_KEEP);
      rd(OFF_LATCH);
      check(q, exp_flash[blk * 64]);
      start(8'h94);
      for (int i = 0; i < 64; i++) exp_flash[blk * 64 + i] = 8'hff;
      wait_done();
      verify();
      start(8'hc4);
      rd(OFF_CONTROL);
      check(q[3:1], 3'b110);
      for (int k = 0; k < 2; k++) begin
         start(8'h84);
         repeat (20) @(posedge pclk);
         if (k == 0) external_master_reset <= 1;
         else watchdog_reset <= 1;
         @(posedge pclk);
         external_master_reset <= 0;
         watchdog_reset <= 0;
         rd(OFF_CONTROL);
         check(q[3:1], 3'b100);
      end
      verify();
      for (int k = 0; k < 2; k++) begin
         d = $random(seed) & 8'hff;
         wr(OFF_NV_ADDR, k == 0 ? 8'h00 : 8'hff);
         wr(OFF_NV_DATA, d);
         start(8'h04);
         rd(OFF_STATUS);
         check(q[1], 0);
         wait_done();
         wr(OFF_NV_DATA, ~d & 8'hff);
         wr(OFF_CONTROL, 8'h01);
         rd(OFF_NV_DATA);
         check(q, d);
      end
      complete_run();
   end
endmodule // tb_flash_block_program_sequencer
`default_nettype wire
